// ### core/rlc_defines.vh
// Overview of operation
// - protocol 17 is UDP, checked like TCP
// - UDP pseudo length taken from UDP length field
// - IPv4 UDP checksum 0000h means unused, no error
// - IPv6 UDP checksum 0000h raises L4 error
// - fragments skip UDP validation
// - IPv4 protocol 1 is ICMP, summed from type
// - IPv6 next header 58 is ICMPv6 with pseudo-header
// - ICMP checks only while ICMP enable set
// - fragments skip ICMP validation
// - protocol 2 is IGMP, summed over payload
// - IGMP checks only while IGMP enable set
// - fragments skip IGMP validation
// - IPv6-in-IPv4: outer IP, TCP/UDP, ICMP; no IGMP
// - IPv4-in-IPv4: no validation, raw checksum only
// - non-IP frames: raw checksum only
// - walk hop, destination, routing headers; fragment header skips
// - non TCP/UDP L4 still gets IPv4 header check
// - L4 passes when sum is FFFFh, else error
// - fragment: MF with zero offset, or offset nonzero
// - IPv4 0800h, IPv6 86DDh after VLAN tags
`ifndef RLC_DEFINES_VH
`define RLC_DEFINES_VH

// register byte offsets
`define RLC_REG_CTRL     8'h00
`define RLC_REG_VLAN     8'h04
`define RLC_REG_STAT     8'h08

// control bits and reset values
`define RLC_CTRL_IP      0
`define RLC_CTRL_TU      1
`define RLC_CTRL_ICMP    2
`define RLC_CTRL_IGMP    3
`define RLC_CTRL_RST     4'h0
`define RLC_VLAN_RST     16'h8100

// status bit positions, raw checksum in [15:0]
`define RLC_ST_IPERR     16
`define RLC_ST_L4ERR     17
`define RLC_ST_FRAG      18
`define RLC_ST_L4CHK     19
`define RLC_ST_NONIP     20

// frame constants
`define RLC_TYPE_V4      16'h0800
`define RLC_TYPE_V6      16'h86DD
`define RLC_TYPE_VLAN    16'h8100
`define RLC_TYPE_MIN     16'h0600
`define RLC_TYPE_END     8'h0D
`define RLC_VLAN_LEN     8'h04
`define RLC_SNAP_LEN     8'h08
`define RLC_V6_HDR_END   16'h0027
`define RLC_IHL_MIN      4'h5
`define RLC_CS_GOOD      16'hFFFF

// protocol numbers
`define RLC_PR_ICMP      8'h01
`define RLC_PR_IGMP      8'h02
`define RLC_PR_IPIP      8'h04
`define RLC_PR_TCP       8'h06
`define RLC_PR_UDP       8'h11
`define RLC_PR_V6        8'h29
`define RLC_PR_ROUTE     8'h2B
`define RLC_PR_FRAG      8'h2C
`define RLC_PR_ICMP6     8'h3A
`define RLC_PR_DEST      8'h3C
`define RLC_PR_HOP       8'h00

`endif

// ### core/rlc_l4_checksum.v
// The register offsets and register access over APB were decided locally.
`include "rlc_defines.vh"
`default_nettype none

module rlc_l4_checksum
(
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // receive byte stream from mac
  input  wire        rx_valid,
  input  wire        rx_sof,
  input  wire        rx_eof,
  input  wire [7:0]  rx_data,
  // checksum status to fifo controller
  output reg         cs_valid,
  output reg         cs_l4_err,
  output reg         cs_ip_err,
  output reg         cs_frag,
  output reg  [15:0] cs_raw
);

  localparam ST_ETH  = 3'h0;
  localparam ST_V4   = 3'h1;
  localparam ST_V6   = 3'h2;
  localparam ST_EXT  = 3'h3;
  localparam ST_L4   = 3'h4;
  localparam ST_SKIP = 3'h5;

  reg  [3:0]  en_q;
  reg  [15:0] vtype_q;
  reg  [20:0] stat_q;
  reg  [2:0]  st_q;
  reg  [7:0]  ec_q;
  reg  [7:0]  tpos_q;
  reg         snap_q;
  reg  [15:0] tbuf_q;
  reg  [15:0] hc_q;
  reg  [15:0] hlen_q;
  reg  [15:0] tot_q;
  reg  [15:0] plen_q;
  reg  [15:0] l4len_q;
  reg  [15:0] lc_q;
  reg  [7:0]  nh_q;
  reg         v4_q;
  reg         seen4_q;
  reg         frag_q;
  reg         tun4_q;
  reg         tun6_q;
  reg         ihlbad_q;
  reg         inl4_q;
  reg         nonip_q;
  reg         par_q;
  reg         done_q;
  reg  [15:0] raw_q;
  reg  [15:0] ipsum_q;
  reg  [15:0] adr_q;
  reg  [15:0] l4_q;
  reg  [15:0] udplen_q;
  reg  [15:0] udpck_q;

  // end-around-carry add
  function [15:0] csadd;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      csadd = s[15:0] + {15'h0000, s[16]};
    end
  endfunction

  // ipv6 next header: 0 layer 4, 1 extension, 2 fragment
  function [1:0] v6_next;
    input [7:0] nh;
    begin
      if (nh == `RLC_PR_HOP || nh == `RLC_PR_ROUTE || nh == `RLC_PR_DEST)
        v6_next = 2'h1;
      else if (nh == `RLC_PR_FRAG)
        v6_next = 2'h2;
      else
        v6_next = 2'h0;
    end
  endfunction

  wire        acc    = rx_valid && !rx_sof;
  wire [15:0] pair   = {tbuf_q[7:0], rx_data};
  wire [15:0] wv     = par_q ? {8'h00, rx_data} : {rx_data, 8'h00};
  wire        hend   = (hc_q == hlen_q - 16'h0001);
  wire [15:0] pl_ext = plen_q - 16'h0001;
  wire [15:0] pl_nx  = (st_q == ST_EXT) ? pl_ext : plen_q;
  wire [1:0]  v6nx   = v6_next(nh_q);
  wire [15:0] v4pl   = tot_q - hlen_q;

  // end of frame decision
  wire        is_tcp  = (nh_q == `RLC_PR_TCP);
  wire        is_udp  = (nh_q == `RLC_PR_UDP);
  wire        is_icmp = (v4_q && nh_q == `RLC_PR_ICMP) ||
                        (!v4_q && nh_q == `RLC_PR_ICMP6);
  wire        is_igmp = v4_q && !tun6_q && nh_q == `RLC_PR_IGMP;
  wire        l4ok    = inl4_q && !frag_q && !tun4_q && !nonip_q;
  wire        chk     = l4ok && (((is_tcp || is_udp) && en_q[`RLC_CTRL_TU]) ||
                        (is_icmp && en_q[`RLC_CTRL_ICMP]) ||
                        (is_igmp && en_q[`RLC_CTRL_IGMP]));
  wire [15:0] pslen   = is_udp ? udplen_q : l4len_q;
  wire [15:0] psum    = csadd(csadd(adr_q, {8'h00, nh_q}), pslen);
  wire        nopsh   = v4_q && (nh_q == `RLC_PR_ICMP || nh_q == `RLC_PR_IGMP);
  wire [15:0] total   = nopsh ? l4_q : csadd(l4_q, psum);
  wire        udp0    = is_udp && udpck_q == 16'h0000;
  wire        l4err   = chk && (udp0 ? !v4_q : (total != `RLC_CS_GOOD));
  wire        iperr   = en_q[`RLC_CTRL_IP] && seen4_q && !tun4_q &&
                        (ihlbad_q || ipsum_q != `RLC_CS_GOOD);

  // stream parser and accumulators
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q     <= ST_SKIP;
      ec_q     <= 8'h00;
      tpos_q   <= `RLC_TYPE_END;
      snap_q   <= 1'b0;
      tbuf_q   <= 16'h0000;
      hc_q     <= 16'h0000;
      hlen_q   <= 16'hFFFF;
      tot_q    <= 16'h0000;
      plen_q   <= 16'h0000;
      l4len_q  <= 16'h0000;
      lc_q     <= 16'h0000;
      nh_q     <= 8'h00;
      v4_q     <= 1'b0;
      seen4_q  <= 1'b0;
      frag_q   <= 1'b0;
      tun4_q   <= 1'b0;
      tun6_q   <= 1'b0;
      ihlbad_q <= 1'b0;
      inl4_q   <= 1'b0;
      nonip_q  <= 1'b0;
      par_q    <= 1'b0;
      done_q   <= 1'b0;
      raw_q    <= 16'h0000;
      ipsum_q  <= 16'h0000;
      adr_q    <= 16'h0000;
      l4_q     <= 16'h0000;
      udplen_q <= 16'h0000;
      udpck_q  <= 16'h0000;
    end
    else
    begin
      done_q <= rx_valid && rx_eof;
      if (rx_valid)
        tbuf_q <= pair;
      if (rx_valid && rx_sof)
      begin
        st_q     <= ST_ETH;
        ec_q     <= 8'h01;
        tpos_q   <= `RLC_TYPE_END;
        snap_q   <= 1'b0;
        v4_q     <= 1'b0;
        seen4_q  <= 1'b0;
        frag_q   <= 1'b0;
        tun4_q   <= 1'b0;
        tun6_q   <= 1'b0;
        ihlbad_q <= 1'b0;
        inl4_q   <= 1'b0;
        nonip_q  <= 1'b0;
        raw_q    <= 16'h0000;
        ipsum_q  <= 16'h0000;
        adr_q    <= 16'h0000;
        l4_q     <= 16'h0000;
        udpck_q  <= 16'h0000;
        nh_q     <= 8'h00;
      end
      else if (acc)
      begin
        if (st_q != ST_ETH)
        begin
          par_q <= !par_q;
          raw_q <= csadd(raw_q, wv);
          hc_q  <= hc_q + 16'h0001;
        end
        case (st_q)
          ST_ETH:
          begin
            ec_q <= ec_q + 8'h01;
            if (ec_q == tpos_q)
            begin
              hc_q  <= 16'h0000;
              par_q <= 1'b0;
              if (pair == vtype_q || pair == `RLC_TYPE_VLAN)
                tpos_q <= tpos_q + `RLC_VLAN_LEN;
              else if (pair < `RLC_TYPE_MIN && !snap_q)
              begin
                snap_q <= 1'b1;
                tpos_q <= tpos_q + `RLC_SNAP_LEN;
              end
              else if (pair == `RLC_TYPE_V4)
              begin
                st_q    <= ST_V4;
                v4_q    <= 1'b1;
                seen4_q <= 1'b1;
              end
              else if (pair == `RLC_TYPE_V6)
                st_q <= ST_V6;
              else
              begin
                st_q    <= ST_SKIP;
                nonip_q <= 1'b1;
              end
            end
          end
          ST_V4:
          begin
            ipsum_q <= csadd(ipsum_q, wv);
            if (hc_q == 16'h0000)
            begin
              ihlbad_q <= rx_data[3:0] < `RLC_IHL_MIN;
              hlen_q   <= (rx_data[3:0] < `RLC_IHL_MIN) ? 16'h0014 :
                          {10'h000, rx_data[3:0], 2'b00};
            end
            if (hc_q == 16'h0003)
              tot_q <= pair;
            if (hc_q == 16'h0007)
              frag_q <= pair[13] || pair[12:0] != 13'h0000;
            if (hc_q == 16'h0009)
              nh_q <= rx_data;
            if (hc_q >= 16'h000C && hc_q <= 16'h0013)
              adr_q <= csadd(adr_q, wv);
            if (hc_q != 16'h0000 && hend)
            begin
              hc_q   <= 16'h0000;
              plen_q <= v4pl;
              if (nh_q == `RLC_PR_V6 && !tun6_q)
              begin
                st_q   <= ST_V6;
                tun6_q <= 1'b1;
                v4_q   <= 1'b0;
                adr_q  <= 16'h0000;
              end
              else if (nh_q == `RLC_PR_IPIP)
              begin
                st_q   <= ST_SKIP;
                tun4_q <= 1'b1;
              end
              else
              begin
                st_q    <= ST_L4;
                inl4_q  <= 1'b1;
                l4len_q <= v4pl;
                lc_q    <= 16'h0000;
              end
            end
          end
          ST_V6, ST_EXT:
          begin
            if (st_q == ST_V6)
            begin
              if (hc_q == 16'h0005)
                plen_q <= pair;
              if (hc_q == 16'h0006)
                nh_q <= rx_data;
              if (hc_q >= 16'h0008)
                adr_q <= csadd(adr_q, wv);
            end
            else
            begin
              plen_q <= pl_ext;
              if (hc_q == 16'h0000)
                nh_q <= rx_data;
              if (hc_q == 16'h0001)
                hlen_q <= {5'h00, rx_data + 8'h01, 3'b000};
            end
            if ((st_q == ST_V6 && hc_q == `RLC_V6_HDR_END) ||
                (st_q == ST_EXT && hend))
            begin
              hc_q   <= 16'h0000;
              hlen_q <= 16'hFFFF;
              case (v6nx)
                2'h1:
                  st_q <= ST_EXT;
                2'h2:
                begin
                  st_q   <= ST_SKIP;
                  frag_q <= 1'b1;
                end
                default:
                begin
                  st_q    <= ST_L4;
                  inl4_q  <= 1'b1;
                  l4len_q <= pl_nx;
                  lc_q    <= 16'h0000;
                end
              endcase
            end
          end
          ST_L4:
          begin
            if (plen_q != 16'h0000)
            begin
              plen_q <= plen_q - 16'h0001;
              lc_q   <= lc_q + 16'h0001;
              l4_q   <= csadd(l4_q, wv);
              if (lc_q == 16'h0005)
                udplen_q <= pair;
              if (lc_q == 16'h0007)
                udpck_q <= pair;
            end
          end
          default:
            st_q <= ST_SKIP;
        endcase
      end
    end
  end

  // status to fifo controller and status register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_valid  <= 1'b0;
      cs_l4_err <= 1'b0;
      cs_ip_err <= 1'b0;
      cs_frag   <= 1'b0;
      cs_raw    <= 16'h0000;
      stat_q    <= 21'h000000;
    end
    else
    begin
      cs_valid <= done_q;
      if (done_q)
      begin
        cs_l4_err <= l4err;
        cs_ip_err <= iperr;
        cs_frag   <= frag_q;
        cs_raw    <= raw_q;
        stat_q    <= {nonip_q, chk, frag_q, l4err, iperr, raw_q};
      end
    end
  end

  // apb: one wait-free access phase, unmapped gives pslverr
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q    <= `RLC_CTRL_RST;
      vtype_q <= `RLC_VLAN_RST;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        case (paddr)
          `RLC_REG_CTRL:
            prdata <= {28'h0000000, en_q};
          `RLC_REG_VLAN:
            prdata <= {16'h0000, vtype_q};
          `RLC_REG_STAT:
            prdata <= {11'h000, stat_q};
          default:
          begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (psel && penable && pready && pwrite)
      begin
        if (paddr == `RLC_REG_CTRL)
          en_q <= pwdata[3:0];
        if (paddr == `RLC_REG_VLAN)
          vtype_q <= pwdata[15:0];
      end
    end
  end

endmodule

`default_nettype wire

// ### testbench/rlc_l4_checksum_assertions.sv
`default_nettype none
module rlc_l4_checksum_assertions (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // stream
  input wire logic        rx_valid,
  input wire logic        rx_sof,
  input wire logic        rx_eof,
  input wire logic [7:0]  rx_data,
  // status
  input wire logic        cs_valid,
  input wire logic        cs_l4_err,
  input wire logic        cs_ip_err,
  input wire logic        cs_frag,
  input wire logic [15:0] cs_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("slverr wrong");
  a_read_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read data");
  a_status_after_eof: assert property (rx_valid && rx_eof |-> ##2 cs_valid)
    else $error("status late");
  a_status_cause: assert property (cs_valid |-> $past(rx_eof, 2))
    else $error("status without frame end");
  a_status_hold: assert property (!cs_valid |-> $stable({cs_l4_err, cs_ip_err, cs_frag, cs_raw}))
    else $error("status moved");
  a_frag_no_error: assert property (cs_valid && cs_frag |-> !cs_l4_err)
    else $error("fragment flagged");
  c_l4_error: cover property (cs_valid && cs_l4_err);
  c_fragment: cover property (cs_valid && cs_frag);
  c_unmapped: cover property (pready && pslverr);
endmodule

bind rlc_l4_checksum rlc_l4_checksum_assertions u_rlc_l4_checksum_assertions (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .rx_valid, .rx_sof, .rx_eof, .rx_data, .cs_valid, .cs_l4_err, .cs_ip_err, .cs_frag, .cs_raw
);
`default_nettype wire

// ### testbench/rlc_mac_model.sv
`default_nettype none
module rlc_mac_model (
  // clock
  input wire logic       pclk,
  // byte stream
  output var logic       rx_valid,
  output var logic       rx_sof,
  output var logic       rx_eof,
  output var logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle gap before every odd byte
  logic slow = 1'b0;
  initial
  begin
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_data = 8'h5A;
  end
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i])
    begin
      if (slow && i[0])
      begin
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data <= ~q[i - 1];
      end
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_eof <= (i == q.size() - 1);
      rx_data <= q[i];
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    rx_eof <= 1'b0;
    rx_data <= ~q[q.size() - 1];
  endtask
endmodule
`default_nettype wire

// ### testbench/rlc_l4_checksum_tb.sv
`include "rlc_defines.vh"
`default_nettype none
module rlc_l4_checksum_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sl;
  logic        rx_valid, rx_sof, rx_eof, cs_valid, cs_l4_err, cs_ip_err, cs_frag;
  logic [7:0]  paddr, rx_data;
  logic [15:0] cs_raw;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  fq[$];
  int          fail_count = 0;
  int          check_count = 0;

  rlc_l4_checksum u_rlc_l4_checksum (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_valid, .rx_sof, .rx_eof, .rx_data, .cs_valid, .cs_l4_err,
    .cs_ip_err, .cs_frag, .cs_raw
  );
  rlc_mac_model u_rlc_mac_model (.pclk, .rx_valid, .rx_sof, .rx_eof, .rx_data);

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [15:0] ocs(input logic [7:0] q[$], input int s);
    logic [31:0] a;
    a = 32'h0;
    for (int i = s; i < q.size(); i += 2)
      a += {q[i], (i + 1 < q.size()) ? q[i + 1] : 8'h00};
    while (a[31:16] != 16'h0)
      a = a[31:16] + a[15:0];
    return a[15:0];
  endfunction

  task automatic run(input bit el4, input bit fr, input logic [15:0] raw);
    u_rlc_mac_model.send(fq);
    for (int i = 0; i < 20 && cs_valid !== 1'b1; i++)
      @(negedge pclk);
    chk("cs_valid", cs_valid, 1);
    chk("cs_l4_err", cs_l4_err, el4);
    chk("cs_frag", cs_frag, fr);
    chk("cs_ip_err", cs_ip_err, 0);
    chk("cs_raw", cs_raw, raw);
    @(posedge pclk);
  endtask

  // builds a frame with an 11-byte layer-4 message and sends it
  task automatic pk(input bit v6, vl, fr, bad, zc, input logic [7:0] pr, input bit el4);
    logic [7:0]  m[$], ps[$], h[$];
    logic [15:0] c;
    m = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h00, 8'h0B, 8'h00, 8'h00, 8'hA1, 8'hB2, 8'hC3};
    ps = {};
    if (v6)
    begin
      for (int i = 0; i < 32; i++)
        ps.push_back(8'(i + 32));
      h = {8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0B, pr, 8'h40, ps};
      ps = {ps, 8'h00, 8'h00, 8'h00, 8'h0B, 8'h00, 8'h00, 8'h00, pr};
    end
    else
    begin
      h = {8'h45, 8'h00, 8'h00, 8'h1F, 8'h00, 8'h00, fr ? 8'h20 : 8'h00, 8'h00, 8'h40, pr,
           8'h00, 8'h00, 8'h0A, 8'h00, 8'h00, 8'h01, 8'h0A, 8'h00, 8'h00, 8'h02};
      c = ~ocs(h, 0);
      h[10] = c[15:8];
      h[11] = c[7:0];
      if (pr == 8'h11)
        ps = {h[12:19], 8'h00, pr, 8'h00, 8'h0B};
    end
    m[pr == 8'h11 ? 6 : 2] = 8'h00;
    m[pr == 8'h11 ? 7 : 3] = 8'h00;
    ps = {ps, m};
    c = ~ocs(ps, 0);
    c = (c == 16'h0) ? 16'hFFFF : c;
    c = zc ? 16'h0 : (bad ? c ^ 16'h0100 : c);
    m[pr == 8'h11 ? 6 : 2] = c[15:8];
    m[pr == 8'h11 ? 7 : 3] = c[7:0];
    fq = {};
    for (int i = 0; i < 12; i++)
      fq.push_back(8'(i + 1));
    if (vl)
      fq = {fq, 8'h81, 8'h00, 8'h00, 8'h05};
    fq = {fq, v6 ? 8'h86 : 8'h08, v6 ? 8'hDD : 8'h00, h, m};
    run(el4, fr, ocs(fq, vl ? 18 : 14));
  endtask

  task automatic t_regs;
    apb(1'b0, `RLC_REG_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(1'b0, `RLC_REG_VLAN, 32'h0);
    chk("vlan", rd, 32'h8100);
    chk("slverr", sl, 0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("slverr", sl, 1);
    chk("unmapped", rd, 32'h0);
    apb(1'b1, `RLC_REG_CTRL, 32'hF);
    apb(1'b0, `RLC_REG_CTRL, 32'h0);
    chk("ctrl", rd, 32'hF);
  endtask

  task automatic t_udp;
    pk(0, 0, 0, 0, 0, 8'h11, 0);
    pk(0, 1, 0, 1, 0, 8'h11, 1);
    pk(0, 0, 0, 0, 1, 8'h11, 0);
    pk(1, 0, 0, 0, 1, 8'h11, 1);
    pk(1, 1, 0, 0, 0, 8'h11, 0);
    pk(0, 0, 1, 1, 0, 8'h11, 0);
    u_rlc_mac_model.slow = 1'b1;
    pk(0, 0, 0, 1, 0, 8'h11, 1);
    u_rlc_mac_model.slow = 1'b0;
  endtask

  task automatic t_icmp;
    pk(0, 0, 0, 1, 0, 8'h01, 1);
    pk(0, 0, 0, 0, 0, 8'h01, 0);
    pk(1, 0, 0, 1, 0, 8'h3A, 1);
    pk(1, 0, 0, 0, 0, 8'h3A, 0);
    pk(0, 0, 1, 1, 0, 8'h01, 0);
    apb(1'b1, `RLC_REG_CTRL, 32'hB);
    pk(0, 0, 0, 1, 0, 8'h01, 0);
  endtask

  task automatic t_igmp;
    apb(1'b1, `RLC_REG_CTRL, 32'hF);
    pk(0, 0, 0, 1, 0, 8'h02, 1);
    pk(0, 0, 0, 0, 0, 8'h02, 0);
    pk(0, 0, 1, 1, 0, 8'h02, 0);
    pk(0, 0, 0, 1, 0, 8'h04, 0);
    pk(0, 0, 0, 1, 0, 8'h2F, 0);
    apb(1'b1, `RLC_REG_CTRL, 32'h5);
    pk(0, 0, 0, 1, 0, 8'h02, 0);
    pk(0, 0, 0, 1, 0, 8'h11, 0);
  endtask

  // plain non-IP frame, then a SNAP frame with a non-IP type
  task automatic t_nonip;
    logic [15:0] r;
    fq = {};
    for (int i = 0; i < 31; i++)
      fq.push_back(8'(i * 7));
    fq[12] = 8'h88;
    fq[13] = 8'hB5;
    run(0, 0, ocs(fq, 14));
    fq[12] = 8'h00;
    fq[13] = 8'h1F;
    fq[20] = 8'h88;
    fq[21] = 8'hB5;
    r = ocs(fq, 22);
    run(0, 0, r);
    apb(1'b0, `RLC_REG_STAT, 32'h0);
    chk("status", rd, {11'h000, 5'h10, r});
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_udp();
    t_icmp();
    t_igmp();
    t_nonip();
    end_sim();
  end

  initial
  begin
    #200000;
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
